// ---- core/lmd_consts.svh ----
// Register map, field positions, reset values and fixed indices of the legacy multiply datapath.
// Overview of operation
// - Multiplier takes 17x17 operands; result to even-started working pair or accumulator.
// - Word file multiply writes product high word and low word registers.
// - Byte file multiply writes only the low word; high word is kept.
// - File multiply is unsigned, file register times the default working register.
// - Default-register moves carry a byte or a word between file memory and it.
// - No other move performs byte transfers to or from file memory.
// - Word moves between file memory and working registers accept any of sixteen.
// - Integer data is signed two's complement, sixteen bits span 0x8000 to 0x7FFF.
// - Sixteen-bit fractional data is two's complement 1.15.
// - Under normal saturation accumulators are 32-bit 1.31 values.
// - Guard select bit extends accumulators to 40 bits using the upper byte.
// - With saturation disabled the guard bits are also used.
// - Fractional guard mode keeps 1.31 radix, accumulator holds 9.31.
// - Non-multiply arithmetic is identical for integer and fractional data.
// - Format select bit: zero fractional, one integer for DSP multiplies.
// - Integer DSP multiply gives full 32-bit product without shift.
// - Fractional DSP multiply shifts the 2.30 product left one bit.
// - Normal saturation keeps results in high and low words, upper byte sign only.
`ifndef LMD_CONSTS_SVH
`define LMD_CONSTS_SVH

`define LMD_REG_CTRL    10'h000
`define LMD_REG_CMD     10'h004
`define LMD_REG_STATUS  10'h008
`define LMD_REG_ACCA_L  10'h010
`define LMD_REG_ACCA_H  10'h014
`define LMD_REG_ACCA_U  10'h018
`define LMD_REG_ACCB_L  10'h01C
`define LMD_REG_ACCB_H  10'h020
`define LMD_REG_ACCB_U  10'h024
`define LMD_DEFAULT_WORK_REG_PAGE   4'h1
`define LMD_FILE_PAGE   2'h1

`define LMD_CTRL_FMT_BIT   0
`define LMD_CTRL_GUARD_BIT 4
`define LMD_CTRL_SATEN_BIT 7
`define LMD_CTRL_RST       16'h0080
`define LMD_CTRL_MASK      16'h0091

`define LMD_NUM_DEFAULT_WORK_REG    16
`define LMD_WIDX_DEF    4'h0
`define LMD_WIDX_PLO    4'h2
`define LMD_WIDX_PHI    4'h3
`define LMD_ACC_RST     40'h00_0000_0000

`endif

// ---- core/lmd_pkg.sv ----
// Types shared by the legacy multiply datapath modules.
package lmd_pkg;

	typedef enum logic [3:0] {
		OP_NOP    = 4'b0000,
		OP_FMUL   = 4'b0001,
		OP_F2W    = 4'b0010,
		OP_W2F    = 4'b0011,
		OP_F2WN   = 4'b0100,
		OP_WN2F   = 4'b0101,
		OP_MULWW  = 4'b0110,
		OP_DSPMPY = 4'b0111,
		OP_DSPMAC = 4'b1000
	} lmd_op_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_WB   = 2'b10
	} lmd_state_e;

	typedef struct packed {
		logic [7:0] rsvd_hi;
		logic [6:0] faddr;
		logic [1:0] rsvd_lo;
		logic       acc_b;
		logic       sgn;
		logic [3:0] ws;
		logic [3:0] wd;
		logic       byte_mode;
		lmd_op_e    op;
	} lmd_cmd_s;

	typedef struct packed {
		logic [16:0] a;
		logic [16:0] b;
	} lmd_mul_req_s;

endpackage : lmd_pkg

// ---- core/lmd_mul17.sv ----
// Registered 17 by 17 signed multiplier.
`timescale 1ns/10ps
module lmd_mul17
	import lmd_pkg::*;
(
	input  wire logic               core_clk,
	input  wire logic               arst_n,
	input  wire lmd_mul_req_s       req,
	output logic signed [33:0]      prod
);

	// One product per clock; unsigned operands arrive with a zero seventeenth bit.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prod <= 34'sh0_0000_0000;
		end else begin
			prod <= $signed(req.a) * $signed(req.b);
		end
	end

endmodule : lmd_mul17

// ---- core/lmd_datapath.sv ----
// Legacy file multiply, default-register moves and DSP multiply formats behind an Avalon slave.
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "lmd_consts.svh"
module lmd_datapath
	import lmd_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest
);

	logic [15:0]  default_work_reg [`LMD_NUM_DEFAULT_WORK_REG];
	logic [15:0]  fmem [64];
	logic [39:0]  acc [2];
	logic [15:0]  ctrl;
	lmd_cmd_s     cmd_q;
	lmd_state_e   state;
	lmd_mul_req_s mreq;
	logic signed [33:0] prod;
	logic         accept;
	logic         bus_wr;
	logic         in_default_work_reg;
	logic         in_file;
	logic [31:0]  rd_word;
	logic [15:0]  fword;
	logic [7:0]   fbyte;
	logic         int_mode;
	logic         guard_mode;
	logic [31:0]  p32;
	logic [39:0]  ext40;
	logic [39:0]  next_acc;
	logic         is_dsp;

	// Merges write data into an old value lane by lane.
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : be_merge

	// Bus decode; requests are only accepted while no command is running.
	assign accept  = (avs_read | avs_write) & ~avs_waitrequest;
	assign bus_wr  = accept & avs_write;
	assign in_default_work_reg = (avs_address[9:6] == `LMD_DEFAULT_WORK_REG_PAGE);
	assign in_file = (avs_address[9:8] == `LMD_FILE_PAGE);

	// Operand views of the addressed file word and byte.
	assign fword = fmem[cmd_q.faddr[6:1]];
	assign fbyte = cmd_q.faddr[0] ? fword[15:8] : fword[7:0];

	// Format select and guard-bit selection from the control register.
	assign int_mode   = ctrl[`LMD_CTRL_FMT_BIT];
	assign guard_mode = ctrl[`LMD_CTRL_GUARD_BIT] | ~ctrl[`LMD_CTRL_SATEN_BIT];
	assign is_dsp     = (cmd_q.op == OP_DSPMPY) | (cmd_q.op == OP_DSPMAC);

	// Operand selection for the shared multiplier.
	always_comb begin
		mreq = '0;
		case (cmd_q.op)
			OP_FMUL: begin
				if (cmd_q.byte_mode) begin
					mreq.a = {9'h000, fbyte};
					mreq.b = {9'h000, default_work_reg[`LMD_WIDX_DEF][7:0]};
				end else begin
					mreq.a = {1'b0, fword};
					mreq.b = {1'b0, default_work_reg[`LMD_WIDX_DEF]};
				end
			end
			OP_MULWW: begin
				mreq.a = {cmd_q.sgn & default_work_reg[cmd_q.ws][15], default_work_reg[cmd_q.ws]};
				mreq.b = {cmd_q.sgn & default_work_reg[cmd_q.wd][15], default_work_reg[cmd_q.wd]};
			end
			OP_DSPMPY, OP_DSPMAC: begin
				mreq.a = {default_work_reg[cmd_q.ws][15], default_work_reg[cmd_q.ws]};
				mreq.b = {default_work_reg[cmd_q.wd][15], default_work_reg[cmd_q.wd]};
			end
			default: begin
				mreq = '0;
			end
		endcase
	end

	lmd_mul17 u_mul (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.req      (mreq),
		.prod     (prod)
	);

	// Product alignment and accumulation for DSP multiplies.
	always_comb begin
		if (int_mode) begin
			p32 = prod[31:0];
		end else begin
			p32 = {prod[30:0], 1'b0};
		end
		ext40 = {{8{p32[31]}}, p32};
		if (cmd_q.op == OP_DSPMAC) begin
			next_acc = acc[cmd_q.acc_b] + ext40;
		end else begin
			next_acc = ext40;
		end
		if (!guard_mode) begin
			next_acc = {{8{next_acc[31]}}, next_acc[31:0]};
		end
	end

	// Command sequencer: moves finish in EXEC, multiplies write back one cycle later.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (bus_wr && avs_address == `LMD_REG_CMD) begin
						state <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					if (cmd_q.op == OP_FMUL || cmd_q.op == OP_MULWW || is_dsp) begin
						state <= ST_WB;
					end else begin
						state <= ST_IDLE;
					end
				end
				ST_WB: begin
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Command and control registers.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_q <= '0;
			ctrl  <= `LMD_CTRL_RST;
		end else if (bus_wr && avs_address == `LMD_REG_CMD) begin
			cmd_q <= lmd_cmd_s'(be_merge(cmd_q, avs_writedata, avs_byteenable));
		end else if (bus_wr && avs_address == `LMD_REG_CTRL) begin
			ctrl <= 16'(be_merge({16'h0000, ctrl}, avs_writedata, avs_byteenable)
				& {16'h0000, `LMD_CTRL_MASK});
		end
	end

	// Working register array: bus writes, moves and product write-back.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < `LMD_NUM_DEFAULT_WORK_REG; i++) begin
				default_work_reg[i] <= 16'h0000;
			end
		end else if (bus_wr && in_default_work_reg) begin
			default_work_reg[avs_address[5:2]] <= 16'(be_merge({16'h0000, default_work_reg[avs_address[5:2]]},
				avs_writedata, avs_byteenable));
		end else if (state == ST_EXEC) begin
			if (cmd_q.op == OP_F2W && cmd_q.byte_mode) begin
				default_work_reg[`LMD_WIDX_DEF][7:0] <= fbyte;
			end else if (cmd_q.op == OP_F2W) begin
				default_work_reg[`LMD_WIDX_DEF] <= fword;
			end else if (cmd_q.op == OP_F2WN && !cmd_q.byte_mode) begin
				default_work_reg[cmd_q.wd] <= fword;
			end
		end else if (state == ST_WB) begin
			if (cmd_q.op == OP_FMUL) begin
				default_work_reg[`LMD_WIDX_PLO] <= prod[15:0];
				if (!cmd_q.byte_mode) begin
					default_work_reg[`LMD_WIDX_PHI] <= prod[31:16];
				end
			end else if (cmd_q.op == OP_MULWW) begin
				default_work_reg[{cmd_q.wd[3:1], 1'b0}] <= prod[15:0];
				default_work_reg[{cmd_q.wd[3:1], 1'b1}] <= prod[31:16];
			end
		end
	end

	// File register memory: bus window and move targets.
	always_ff @(posedge core_clk) begin
		if (bus_wr && in_file) begin
			fmem[avs_address[7:2]] <= 16'(be_merge({16'h0000, fmem[avs_address[7:2]]},
				avs_writedata, avs_byteenable));
		end else if (state == ST_EXEC && cmd_q.op == OP_W2F) begin
			if (!cmd_q.byte_mode) begin
				fmem[cmd_q.faddr[6:1]] <= default_work_reg[`LMD_WIDX_DEF];
			end else if (cmd_q.faddr[0]) begin
				fmem[cmd_q.faddr[6:1]][15:8] <= default_work_reg[`LMD_WIDX_DEF][7:0];
			end else begin
				fmem[cmd_q.faddr[6:1]][7:0] <= default_work_reg[`LMD_WIDX_DEF][7:0];
			end
		end else if (state == ST_EXEC && cmd_q.op == OP_WN2F) begin
			fmem[cmd_q.faddr[6:1]] <= default_work_reg[cmd_q.ws];
		end
	end

	// Accumulators: bus access to the six words and DSP write-back.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc[0] <= `LMD_ACC_RST;
			acc[1] <= `LMD_ACC_RST;
		end else if (bus_wr) begin
			case (avs_address)
				`LMD_REG_ACCA_L: acc[0][15:0]  <= avs_writedata[15:0];
				`LMD_REG_ACCA_H: acc[0][31:16] <= avs_writedata[15:0];
				`LMD_REG_ACCA_U: acc[0][39:32] <= avs_writedata[7:0];
				`LMD_REG_ACCB_L: acc[1][15:0]  <= avs_writedata[15:0];
				`LMD_REG_ACCB_H: acc[1][31:16] <= avs_writedata[15:0];
				`LMD_REG_ACCB_U: acc[1][39:32] <= avs_writedata[7:0];
				default: begin
				end
			endcase
		end else if (state == ST_WB && is_dsp) begin
			acc[cmd_q.acc_b] <= next_acc;
		end
	end

	// Read data selection; unmapped addresses read zero.
	always_comb begin
		rd_word = 32'h0000_0000;
		if (in_default_work_reg) begin
			rd_word = {16'h0000, default_work_reg[avs_address[5:2]]};
		end else if (in_file) begin
			rd_word = {16'h0000, fmem[avs_address[7:2]]};
		end else begin
			case (avs_address)
				`LMD_REG_CTRL:   rd_word = {16'h0000, ctrl};
				`LMD_REG_CMD:    rd_word = cmd_q;
				`LMD_REG_STATUS: rd_word = {30'h0000_0000, state};
				`LMD_REG_ACCA_L: rd_word = {16'h0000, acc[0][15:0]};
				`LMD_REG_ACCA_H: rd_word = {16'h0000, acc[0][31:16]};
				`LMD_REG_ACCA_U: rd_word = {{24{acc[0][39]}}, acc[0][39:32]};
				`LMD_REG_ACCB_L: rd_word = {16'h0000, acc[1][15:0]};
				`LMD_REG_ACCB_H: rd_word = {16'h0000, acc[1][31:16]};
				`LMD_REG_ACCB_U: rd_word = {{24{acc[1][39]}}, acc[1][39:32]};
				default:         rd_word = 32'h0000_0000;
			endcase
		end
	end

	// Wait request drops for one cycle per access, only while idle.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else if (!avs_waitrequest) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read || avs_write) && state == ST_IDLE) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= rd_word;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	fmul_word_a: assert property ((state == ST_WB && cmd_q.op == OP_FMUL && !cmd_q.byte_mode)
		|=> default_work_reg[3] == $past(prod[31:16]) && default_work_reg[2] == $past(prod[15:0]))
		else $error("word file multiply wrote wrong product halves");
	fmul_byte_a: assert property ((state == ST_WB && cmd_q.op == OP_FMUL && cmd_q.byte_mode)
		|=> default_work_reg[3] == $past(default_work_reg[3]) && default_work_reg[2] == $past(prod[15:0]))
		else $error("byte file multiply disturbed the high word");
	fmul_unsigned_a: assert property ((state == ST_EXEC && cmd_q.op == OP_FMUL)
		|-> !mreq.a[16] && !mreq.b[16]
		&& (!cmd_q.byte_mode || (mreq.a[16:8] == 9'h000 && mreq.b[16:8] == 9'h000)))
		else $error("file multiply operand not zero extended");
	move_byte_a: assert property ((state == ST_EXEC && cmd_q.op == OP_F2W && cmd_q.byte_mode)
		|=> default_work_reg[0][15:8] == $past(default_work_reg[0][15:8]) && default_work_reg[0][7:0] == $past(fbyte))
		else $error("byte move to default register wrong");
	no_byte_wn_a: assert property ((state == ST_EXEC && cmd_q.op == OP_F2WN && cmd_q.byte_mode)
		|=> default_work_reg[cmd_q.wd] == $past(default_work_reg[cmd_q.wd]))
		else $error("byte move to a general register took effect");
	any_default_work_reg_a: assert property ((state == ST_EXEC && cmd_q.op == OP_F2WN && !cmd_q.byte_mode)
		|=> default_work_reg[cmd_q.wd] == $past(fword))
		else $error("word move to general register wrong");
	sign_upper_a: assert property ((state == ST_WB && is_dsp && !guard_mode)
		|=> acc[cmd_q.acc_b][39:32] == {8{acc[cmd_q.acc_b][31]}})
		else $error("upper byte not sign extension in normal mode");
	frac_shift_a: assert property ((state == ST_WB && cmd_q.op == OP_DSPMPY && !int_mode
		&& guard_mode) |=> acc[cmd_q.acc_b][31:0] == {$past(prod[30:0]), 1'b0})
		else $error("fractional product not shifted by one");
	int_noshift_a: assert property ((state == ST_WB && cmd_q.op == OP_DSPMPY && int_mode)
		|=> acc[cmd_q.acc_b][31:0] == $past(prod[31:0]))
		else $error("integer product was shifted");
	guard_mac_a: assert property ((state == ST_WB && cmd_q.op == OP_DSPMAC && guard_mode)
		|=> acc[cmd_q.acc_b] == $past(acc[cmd_q.acc_b]) + $past(ext40))
		else $error("guard mode accumulate lost upper bits");
	cmd_busy_a: assert property ((bus_wr && avs_address == `LMD_REG_CMD)
		|=> state == ST_EXEC ##1 avs_waitrequest)
		else $error("command did not start or bus not stalled");

	fmul_flow_c: cover property (state == ST_EXEC && cmd_q.op == OP_FMUL ##1 state == ST_WB);
	mac_guard_c: cover property (state == ST_WB && cmd_q.op == OP_DSPMAC && guard_mode);
	byte_store_c: cover property (state == ST_EXEC && cmd_q.op == OP_W2F && cmd_q.byte_mode);

endmodule : lmd_datapath

// ---- testbench/lmd_bus_master.sv ----
// Avalon-MM master model standing in for the decoder side of the datapath.
`timescale 1ns/10ps
module lmd_bus_master
	import lmd_pkg::*;
(
	input  wire logic        core_clk,
	output logic      [9:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata,
	output logic      [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest
);
	// Idle bus values at time zero.
	initial begin
		avs_address    = 10'h000;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h0000_0000;
		avs_byteenable = 4'hF;
	end

	// Holds one request until the edge that sees waitrequest low, then releases it.
	// Released write data is inverted so a stale value is never mistaken for a live one.
	task automatic xfer(input logic rd, input logic [9:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata);
		@(posedge core_clk);
		avs_address   <= addr;
		avs_read      <= rd;
		avs_write     <= ~rd;
		avs_writedata <= wdata;
		// Right after an edge the slave outputs still hold what the slave showed at that edge.
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		rdata = avs_readdata;
		avs_read      <= 1'b0;
		avs_write     <= 1'b0;
		avs_writedata <= ~wdata;
	endtask : xfer
endmodule : lmd_bus_master

// ---- testbench/testbench.sv ----
// Self-checking bench for the legacy multiply datapath.
`timescale 1ns/10ps
module testbench
	import lmd_pkg::*;
;
	typedef struct packed {
		logic [15:0] fval;
		logic [15:0] w0;
		logic [31:0] cmd;
		logic [9:0]  raddr;
		logic [31:0] exp;
	} lmd_row_s;

	logic        core_clk;
	logic        arst_n;
	logic [9:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	int          num_errors;
	int          samples_checked;
	lmd_row_s    rows [11];
	logic [15:0] ctl [3];

	lmd_datapath i_lmd_datapath (
		.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest)
	);

	lmd_bus_master i_lmd_bus_master (
		.core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest)
	);

	// Clock at 200 MHz.
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// Prints the verdict and ends the run.
	task automatic tally_and_finish();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish

	// Writes one register.
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		i_lmd_bus_master.xfer(1'b0, a, d, dummy);
	endtask : wr

	// Reads one register and compares it with the expected value.
	task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
		logic [31:0] got;
		i_lmd_bus_master.xfer(1'b1, a, 32'h0000_0000, got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t addr %h read %h expected %h", $time, a, got, exp);
		end
	endtask : rd_chk

	// Cuts a hung run short.
	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		tally_and_finish();
	end

	// Main sequence: reset values, table of file operations, then multiplier cases.
	initial begin
		num_errors      = 0;
		samples_checked = 0;
		arst_n          = 1'b0;
		rows[0]  = '{16'h1255, 16'h7705, 32'h0000_0001, 10'h048, 32'h0000_DEA9};
		rows[1]  = '{16'h1255, 16'h7705, 32'h0000_0001, 10'h04C, 32'h0000_0885};
		rows[2]  = '{16'h1255, 16'h1235, 32'h0000_0011, 10'h048, 32'h0000_1199};
		rows[3]  = '{16'h1255, 16'h1235, 32'h0000_0011, 10'h04C, 32'h0000_1000};
		rows[4]  = '{16'hFFFF, 16'hFFFF, 32'h0000_0001, 10'h04C, 32'h0000_FFFE};
		rows[5]  = '{16'hABCD, 16'h0000, 32'h0002_0012, 10'h040, 32'h0000_00AB};
		rows[6]  = '{16'hABCD, 16'h1234, 32'h0000_0013, 10'h100, 32'h0000_AB34};
		rows[7]  = '{16'h5A5A, 16'h0000, 32'h0000_0002, 10'h040, 32'h0000_5A5A};
		rows[8]  = '{16'h7777, 16'h0000, 32'h0000_00B4, 10'h054, 32'h0000_0000};
		rows[9]  = '{16'h7777, 16'h0000, 32'h0000_01E4, 10'h07C, 32'h0000_7777};
		rows[10] = '{16'h7777, 16'h3C3C, 32'h0004_0005, 10'h104, 32'h0000_3C3C};
		ctl[0] = 16'h0090;
		ctl[1] = 16'h0000;
		ctl[2] = 16'h0080;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		rd_chk(10'h000, 32'h0000_0080);
		rd_chk(10'h008, 32'h0000_0000);
		rd_chk(10'h3FC, 32'h0000_0000);
		foreach (rows[i]) begin
			wr(10'h100, {16'h0000, rows[i].fval});
			wr(10'h040, {16'h0000, rows[i].w0});
			wr(10'h04C, 32'h0000_1000);
			wr(10'h004, rows[i].cmd);
			rd_chk(rows[i].raddr, rows[i].exp);
		end
		// Working-register multiply into an even pair, unsigned then signed.
		wr(10'h050, 32'h0000_4000);
		wr(10'h058, 32'h0000_4000);
		wr(10'h004, 32'h0000_08C6);
		rd_chk(10'h05C, 32'h0000_1000);
		wr(10'h050, 32'h0000_FFFF);
		wr(10'h058, 32'h0000_4000);
		wr(10'h004, 32'h0000_28C6);
		rd_chk(10'h058, 32'h0000_C000);
		rd_chk(10'h05C, 32'h0000_FFFF);
		// Half times half: fractional shifts the product, integer does not.
		wr(10'h050, 32'h0000_4000);
		wr(10'h054, 32'h0000_4000);
		wr(10'h000, 32'h0000_0080);
		wr(10'h004, 32'h0000_08A7);
		rd_chk(10'h014, 32'h0000_2000);
		rd_chk(10'h010, 32'h0000_0000);
		wr(10'h000, 32'h0000_0081);
		wr(10'h004, 32'h0000_08A7);
		rd_chk(10'h014, 32'h0000_1000);
		// Most negative integer times one sign-extends into the upper byte.
		wr(10'h050, 32'h0000_8000);
		wr(10'h054, 32'h0000_0001);
		wr(10'h004, 32'h0000_08A7);
		rd_chk(10'h014, 32'h0000_FFFF);
		rd_chk(10'h010, 32'h0000_8000);
		rd_chk(10'h018, 32'hFFFF_FFFF);
		// Two near-full fractional products carry into bit 31 of accumulator B.
		wr(10'h050, 32'h0000_7FFF);
		wr(10'h054, 32'h0000_7FFF);
		foreach (ctl[k]) begin
			wr(10'h000, {16'h0000, ctl[k]});
			wr(10'h004, 32'h0000_48A7);
			wr(10'h004, 32'h0000_48A8);
			rd_chk(10'h020, 32'h0000_FFFC);
			rd_chk(10'h01C, 32'h0000_0004);
			rd_chk(10'h024, (k == 2) ? 32'hFFFF_FFFF : 32'h0000_0000);
		end
		// A reset in mid-run returns control, working registers and accumulators to reset values.
		@(posedge core_clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		rd_chk(10'h000, 32'h0000_0080);
		rd_chk(10'h040, 32'h0000_0000);
		rd_chk(10'h024, 32'h0000_0000);
		tally_and_finish();
	end
endmodule : testbench
